// ---- logic/prot_regs_pkg.sv ----
// Constants, register map and state encoding for the protection register bank
// Contract
// - Control bit 0 enables output current diagnostic
// - Overload policy one clears level select bits
// - Overload policy zero restores previous level automatically
// - Thermal policy one clears level select bits
// - Thermal policy zero restores previous level automatically
// - Control bit 7 selects converter compensation
// - Control register resets to zero; reserved bits
// - Status registers are read only
// - Status bit 0 shows overload
// - Status bit 2 shows output undervoltage
// - Status bit 4 shows deglitched pull-down overcurrent
// - Status bit 6 overtemperature with hysteresis
// - Status bit 7 shows input undervoltage
// - Level select in bits 0-3 at 0x2
// - Reads continue while host acknowledges low
package prot_regs_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [2:0] ADDR_STATUS_ONE = 3'h0;
    localparam logic [2:0] ADDR_STATUS_TWO = 3'h1;
    localparam logic [2:0] ADDR_LEVEL_SELECT = 3'h2;
    localparam logic [2:0] ADDR_PROTECTION_CONTROL = 3'h5;

    localparam int CTRL_DIAG_BIT = 0;
    localparam int CTRL_OVL_POLICY_BIT = 3;
    localparam int CTRL_HEAT_POLICY_BIT = 6;
    localparam int CTRL_COMP_BIT = 7;

    localparam int STAT_OVL_BIT = 0;
    localparam int STAT_LOW_OUT_BIT = 2;
    localparam int STAT_PULL_BIT = 4;
    localparam int STAT_HEAT_BIT = 6;
    localparam int STAT_LOW_IN_BIT = 7;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] LEVEL_RESET = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Serial bus device address; value is arbitrary
    localparam logic [6:0] DEVICE_ADDR = 7'h08;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULL_DEGLITCH_NS = 10000;
    localparam int PULL_DEGLITCH_CYCLES = PULL_DEGLITCH_NS / CLK_PERIOD_NS;
    localparam int SENSE_INPUTS = 8;

    typedef enum logic [3:0] {
        BUS_IDLE = 4'h0,
        BUS_ADDR = 4'h1,
        BUS_ADDR_ACK = 4'h2,
        BUS_PTR = 4'h3,
        BUS_PTR_ACK = 4'h4,
        BUS_WDATA = 4'h5,
        BUS_WDATA_ACK = 4'h6,
        BUS_RDATA = 4'h7,
        BUS_RACK = 4'h8
    } bus_state_e;

endpackage

// ---- logic/sync_bank.sv ----
// Two-stage synchroniser bank for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module sync_bank #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] stable_d;

    // First stage feeds only the second stage
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : gBit
            always_comb begin
                meta_d[i] = asyncIn[i];
                stable_d[i] = meta_q[i];
            end
            always_ff @(posedge clk or negedge rstN) begin
                if (!rstN) begin
                    meta_q[i] <= 1'b0;
                    syncOut[i] <= 1'b0;
                end else begin
                    meta_q[i] <= meta_d[i];
                    syncOut[i] <= stable_d[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ---- logic/deglitch_filter.sv ----
// Persistence filter: output rises once the input has held high long enough
`timescale 1ns/1ps
`default_nettype none
module deglitch_filter (
    input wire logic clk,
    input wire logic rstN,
    input wire logic rawIn,
    output logic filtered
);
    import prot_regs_pkg::*;

    localparam logic [15:0] HOLD = 16'(PULL_DEGLITCH_CYCLES);
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic filt_d;

    always_comb begin
        count_d = 16'h0000;
        filt_d = 1'b0;
        if (rawIn) begin
            // Short pulses restart the count and never reach the flag
            count_d = (count_q == HOLD) ? count_q : count_q + 16'h0001;
            filt_d = (count_q == HOLD);
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            count_q <= 16'h0000;
            filtered <= 1'b0;
        end else begin
            count_q <= count_d;
            filtered <= filt_d;
        end
    end
endmodule
`default_nettype wire

// ---- logic/protection_config_and_status_regs.sv ----
// Protection control and diagnostic status registers behind the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module protection_config_and_status_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic overloadDetect,
    input wire logic outputUnderVoltage,
    input wire logic pulldownOvercurrent,
    input wire logic tempAboveHigh,
    input wire logic tempBelowLow,
    input wire logic inputUnderVoltage,
    output logic [3:0] outputLevelSelect,
    output logic outputEnable,
    output logic currentDiagEnable,
    output logic compHighEsr
);
    import prot_regs_pkg::*;

    // ---------------------------------------------------------------
    // Reset release
    // ---------------------------------------------------------------
    logic rstMeta_q;
    logic rstSync_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [SENSE_INPUTS-1:0] rawIn;
    logic [SENSE_INPUTS-1:0] syncIn;
    logic sclS;
    logic sdaS;
    logic ovlNow;
    logic lowOutNow;
    logic pullNow;
    logic hotNow;
    logic coolNow;
    logic lowInNow;
    logic pullFilt;

    assign rawIn = {inputUnderVoltage, tempBelowLow, tempAboveHigh, pulldownOvercurrent,
                    outputUnderVoltage, overloadDetect, sdaIn, scl};
    assign sclS = syncIn[0];
    assign sdaS = syncIn[1];
    assign ovlNow = syncIn[2];
    assign lowOutNow = syncIn[3];
    assign pullNow = syncIn[4];
    assign hotNow = syncIn[5];
    assign coolNow = syncIn[6];
    assign lowInNow = syncIn[7];

    sync_bank #(.W(SENSE_INPUTS)) uSync (
        .clk(clk),
        .rstN(rstSync_q),
        .asyncIn(rawIn),
        .syncOut(syncIn)
    );

    deglitch_filter uPull (
        .clk(clk),
        .rstN(rstSync_q),
        .rawIn(pullNow),
        .filtered(pullFilt)
    );

    // ---------------------------------------------------------------
    // Status flags
    // ---------------------------------------------------------------
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic overTemp_q;
    logic overTemp_d;

    always_comb begin
        overTemp_d = overTemp_q;
        if (hotNow) begin
            overTemp_d = 1'b1;
        end else if (coolNow) begin
            overTemp_d = 1'b0;
        end
        status_d = BYTE_ZERO;
        status_d[STAT_OVL_BIT] = ovlNow;
        status_d[STAT_LOW_OUT_BIT] = lowOutNow;
        status_d[STAT_PULL_BIT] = pullFilt;
        status_d[STAT_HEAT_BIT] = overTemp_d;
        status_d[STAT_LOW_IN_BIT] = lowInNow;
    end

    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            overTemp_q <= 1'b0;
            status_q <= BYTE_ZERO;
        end else begin
            overTemp_q <= overTemp_d;
            status_q <= status_d;
        end
    end

    // ---------------------------------------------------------------
    // Bus condition detection
    // ---------------------------------------------------------------
    logic sclPrev_q;
    logic sdaPrev_q;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;

    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            // Match the synchroniser's reset level; an idle-high scl still shows one rising edge after reset, ignored in BUS_IDLE
            sclPrev_q <= 1'b0;
            sdaPrev_q <= 1'b0;
        end else begin
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
        end
    end

    assign sclRise = sclS & ~sclPrev_q;
    assign sclFall = ~sclS & sclPrev_q;
    assign startCond = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
    assign stopCond = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

    // ---------------------------------------------------------------
    // Register storage
    // ---------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [3:0] level_q;

    function automatic logic [7:0] regRead(input logic [2:0] addr, input logic [7:0] stat,
                                           input logic [3:0] lvl, input logic [7:0] ctl);
        logic [7:0] val;
        val = BYTE_ZERO;
        case (addr)
            ADDR_STATUS_ONE: val = stat;
            ADDR_LEVEL_SELECT: val = {4'h0, lvl};
            ADDR_PROTECTION_CONTROL: val = ctl;
            default: val = BYTE_ZERO;
        endcase
        return val;
    endfunction

    // ---------------------------------------------------------------
    // Serial bus engine
    // ---------------------------------------------------------------
    bus_state_e state_q;
    bus_state_e state_d;
    logic [3:0] bitCnt_q;
    logic [3:0] bitCnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [2:0] ptr_q;
    logic [2:0] ptr_d;
    logic isRead_q;
    logic isRead_d;
    logic hostAck_q;
    logic hostAck_d;
    logic sdaOe_d;
    logic wrStrobe;
    logic [7:0] wrData;

    always_comb begin
        state_d = state_q;
        bitCnt_d = bitCnt_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        isRead_d = isRead_q;
        hostAck_d = hostAck_q;
        sdaOe_d = sdaOe;
        wrStrobe = 1'b0;
        wrData = shift_q;
        if (startCond) begin
            state_d = BUS_ADDR;
            bitCnt_d = 4'h0;
            sdaOe_d = 1'b0;
        end else if (stopCond) begin
            state_d = BUS_IDLE;
            sdaOe_d = 1'b0;
        end else begin
            case (state_q)
                BUS_ADDR, BUS_PTR, BUS_WDATA: begin
                    if (sclRise) begin
                        shift_d = {shift_q[6:0], sdaS};
                        bitCnt_d = bitCnt_q + 4'h1;
                    end else if (sclFall && bitCnt_q == BITS_PER_BYTE) begin
                        bitCnt_d = 4'h0;
                        sdaOe_d = 1'b1;
                        if (state_q == BUS_ADDR) begin
                            isRead_d = shift_q[0];
                            state_d = BUS_ADDR_ACK;
                            if (shift_q[7:1] != DEVICE_ADDR) begin
                                state_d = BUS_IDLE;
                                sdaOe_d = 1'b0;
                            end
                        end else if (state_q == BUS_PTR) begin
                            ptr_d = shift_q[2:0];
                            state_d = BUS_PTR_ACK;
                        end else begin
                            wrStrobe = 1'b1;
                            state_d = BUS_WDATA_ACK;
                        end
                    end
                end
                BUS_ADDR_ACK: begin
                    if (sclFall) begin
                        if (isRead_q) begin
                            shift_d = regRead(ptr_q, status_q, level_q, ctrl_q);
                            sdaOe_d = ~shift_d[7];
                            state_d = BUS_RDATA;
                        end else begin
                            sdaOe_d = 1'b0;
                            state_d = BUS_PTR;
                        end
                    end
                end
                BUS_PTR_ACK, BUS_WDATA_ACK: begin
                    if (sclFall) begin
                        if (state_q == BUS_WDATA_ACK) begin
                            ptr_d = ptr_q + 3'h1;
                        end
                        sdaOe_d = 1'b0;
                        state_d = BUS_WDATA;
                    end
                end
                BUS_RDATA: begin
                    if (sclRise) begin
                        bitCnt_d = bitCnt_q + 4'h1;
                    end else if (sclFall) begin
                        if (bitCnt_q == BITS_PER_BYTE) begin
                            sdaOe_d = 1'b0;
                            state_d = BUS_RACK;
                        end else begin
                            sdaOe_d = ~shift_q[3'(4'h7 - bitCnt_q)];
                        end
                    end
                end
                BUS_RACK: begin
                    if (sclRise) begin
                        hostAck_d = ~sdaS;
                    end else if (sclFall) begin
                        if (hostAck_q) begin
                            // Host held acknowledge low: send the next register
                            ptr_d = ptr_q + 3'h1;
                            shift_d = regRead(ptr_d, status_q, level_q, ctrl_q);
                            sdaOe_d = ~shift_d[7];
                            bitCnt_d = 4'h0;
                            state_d = BUS_RDATA;
                        end else begin
                            state_d = BUS_IDLE;
                        end
                    end
                end
                default: begin
                    sdaOe_d = 1'b0;
                    state_d = BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            state_q <= BUS_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= BYTE_ZERO;
            ptr_q <= 3'h0;
            isRead_q <= 1'b0;
            hostAck_q <= 1'b0;
            sdaOe <= 1'b0;
            sdaOut <= 1'b0;
        end else begin
            state_q <= state_d;
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            isRead_q <= isRead_d;
            hostAck_q <= hostAck_d;
            sdaOe <= sdaOe_d;
            sdaOut <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Control registers and protection policy
    // ---------------------------------------------------------------
    logic [7:0] ctrl_d;
    logic [3:0] level_d;
    logic [3:0] levelOut_d;
    logic outEn_d;
    logic ovlCut;
    logic heatCut;
    logic holdOff;

    always_comb begin
        ctrl_d = ctrl_q;
        level_d = level_q;
        // Status addresses simply drop writes
        if (wrStrobe && ptr_q == ADDR_PROTECTION_CONTROL) begin
            ctrl_d = BYTE_ZERO;
            ctrl_d[CTRL_DIAG_BIT] = wrData[CTRL_DIAG_BIT];
            ctrl_d[CTRL_OVL_POLICY_BIT] = wrData[CTRL_OVL_POLICY_BIT];
            ctrl_d[CTRL_HEAT_POLICY_BIT] = wrData[CTRL_HEAT_POLICY_BIT];
            ctrl_d[CTRL_COMP_BIT] = wrData[CTRL_COMP_BIT];
        end
        if (wrStrobe && ptr_q == ADDR_LEVEL_SELECT) begin
            level_d = wrData[3:0];
        end
        ovlCut = status_q[STAT_OVL_BIT] && ctrl_q[CTRL_OVL_POLICY_BIT];
        heatCut = status_q[STAT_HEAT_BIT] && ctrl_q[CTRL_HEAT_POLICY_BIT];
        // Fault clearing beats a host write landing in the same cycle
        if (ovlCut) begin
            level_d = LEVEL_RESET;
        end
        if (heatCut) begin
            level_d = LEVEL_RESET;
        end
        // Auto-restart policy keeps the stored level and only gates the output
        holdOff = status_q[STAT_OVL_BIT] || status_q[STAT_HEAT_BIT];
        levelOut_d = holdOff ? LEVEL_RESET : level_q;
        outEn_d = !holdOff && (level_q != LEVEL_RESET);
    end

    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            ctrl_q <= CTRL_RESET;
            level_q <= LEVEL_RESET;
            outputLevelSelect <= LEVEL_RESET;
            outputEnable <= 1'b0;
            currentDiagEnable <= 1'b0;
            compHighEsr <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            level_q <= level_d;
            outputLevelSelect <= levelOut_d;
            outputEnable <= outEn_d;
            currentDiagEnable <= ctrl_q[CTRL_DIAG_BIT];
            compHighEsr <= ctrl_q[CTRL_COMP_BIT];
        end
    end

endmodule
`default_nettype wire

// ---- testbench/prot_regs_chk.sv ----
// Concurrent checks on the ports of the protection register bank
`timescale 1ns/1ps
`default_nettype none
module prot_regs_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic overloadDetect,
    input wire logic tempAboveHigh,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic [3:0] outputLevelSelect,
    input wire logic outputEnable,
    input wire logic currentDiagEnable,
    input wire logic compHighEsr
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ----
    // Properties
    // ----
    reset_zero_a: assert property (
        $rose(rst_n) |-> {outputLevelSelect, outputEnable, currentDiagEnable, compHighEsr} == 7'h00)
        else $error("outputs not cleared by reset");
    overload_off_a: assert property (
        overloadDetect [*8] |-> outputLevelSelect == 4'h0 && !outputEnable)
        else $error("output still on during overload");
    thermal_off_a: assert property (
        tempAboveHigh [*8] |-> !outputEnable && outputLevelSelect == 4'h0)
        else $error("output still on during overtemperature");
    enable_level_a: assert property (
        outputEnable |-> outputLevelSelect != 4'h0)
        else $error("output on with zero level");
    restore_clean_a: assert property (
        $rose(outputEnable) |-> !overloadDetect && !tempAboveHigh)
        else $error("output came back during a fault");
    comp_write_a: assert property (
        $changed(compHighEsr) |-> !scl && !$past(scl, 2))
        else $error("compensation changed outside a bus write");
    diag_stable_a: assert property (
        scl [*2] |-> $stable(currentDiagEnable))
        else $error("diagnostic enable moved while bus clock high");
    sda_timing_a: assert property (
        $changed(sdaOe) |-> !scl)
        else $error("data line moved while bus clock high");
    open_drain_a: assert property (
        sdaOe |-> sdaOut == 1'b0)
        else $error("data line driven high");
endmodule
bind protection_config_and_status_regs prot_regs_chk chk (.clk(clk), .rst_n(rst_n), .scl(scl),
    .overloadDetect(overloadDetect), .tempAboveHigh(tempAboveHigh), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .outputLevelSelect(outputLevelSelect), .outputEnable(outputEnable),
    .currentDiagEnable(currentDiagEnable), .compHighEsr(compHighEsr));
`default_nettype wire

// ---- testbench/two_wire_host.sv ----
// Two-wire bus host model that reaches the register bank
`timescale 1ns/1ps
`default_nettype none
module two_wire_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sdaOe
);
    // ----
    // Bus cycles
    // ----
    // Half a low phase; the device wants phases of at least 8 cycles
    localparam int HALF = 10;
    logic ackSeen;
    logic [7:0] rdBuf [8];
    initial begin
        scl = 1'b1;
        sdaOe = 1'b0;
    end
    task automatic gap();
        repeat (HALF) @(negedge clk);
    endtask
    task automatic start();
        sdaOe = 1'b0;
        gap();
        scl = 1'b1;
        gap();
        sdaOe = 1'b1;
        gap();
        scl = 1'b0;
        gap();
    endtask
    task automatic stop();
        sdaOe = 1'b1;
        gap();
        scl = 1'b1;
        gap();
        sdaOe = 1'b0;
        gap();
    endtask
    // Data moves only a full gap after the clock fall, never beside it
    task automatic bitOut(input logic b, output logic s);
        sdaOe = !b;
        gap();
        scl = 1'b1;
        gap();
        s = sda;
        scl = 1'b0;
        gap();
    endtask
    task automatic xfer(input logic [7:0] tx, input logic hostAck, output logic [7:0] rx,
                        output logic devAck);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitOut(tx[i], s);
            rx[i] = s;
        end
        bitOut(hostAck, s);
        devAck = !s;
    endtask
    task automatic wrReg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d);
        logic [7:0] rx;
        logic a;
        start();
        xfer({dev, 1'b0}, 1'b1, rx, ackSeen);
        xfer(ptr, 1'b1, rx, a);
        xfer(d, 1'b1, rx, a);
        stop();
    endtask
    task automatic rdRegs(input logic [6:0] dev, input logic [7:0] ptr, input int n);
        logic [7:0] rx;
        logic a;
        start();
        xfer({dev, 1'b0}, 1'b1, rx, a);
        xfer(ptr, 1'b1, rx, a);
        stop();
        start();
        xfer({dev, 1'b1}, 1'b1, rx, ackSeen);
        for (int k = 0; k < n; k++) begin
            xfer(8'hff, k == n - 1, rdBuf[k], a);
        end
        stop();
    endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the protection register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import prot_regs_pkg::*;
    logic clk, rst_n, scl, hostOe, sdaOut, sdaOe, outputEnable, currentDiagEnable, compHighEsr;
    logic overloadDetect, outputUnderVoltage, pulldownOvercurrent;
    logic tempAboveHigh, tempBelowLow, inputUnderVoltage;
    logic [3:0] outputLevelSelect;
    int nErrors = 0;
    int testsRun = 0;
    // Pulled-up line: low while either party pulls it
    wire logic sda = !(sdaOe || hostOe);
    protection_config_and_status_regs dut (.clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .overloadDetect(overloadDetect),
        .outputUnderVoltage(outputUnderVoltage), .pulldownOvercurrent(pulldownOvercurrent),
        .tempAboveHigh(tempAboveHigh), .tempBelowLow(tempBelowLow),
        .inputUnderVoltage(inputUnderVoltage), .outputLevelSelect(outputLevelSelect),
        .outputEnable(outputEnable), .currentDiagEnable(currentDiagEnable),
        .compHighEsr(compHighEsr));
    two_wire_host host (.clk(clk), .sda(sda), .scl(scl), .sdaOe(hostOe));
    always #5 clk = ~clk;
    // ----
    // Helpers
    // ----
    task automatic giveVerdict();
        $display("comparisons %0d mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nErrors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] outs();
        return {1'b0, compHighEsr, currentDiagEnable, outputEnable, outputLevelSelect};
    endfunction
    task automatic sense(input logic [5:0] v);
        @(negedge clk);
        {overloadDetect, outputUnderVoltage, pulldownOvercurrent, tempAboveHigh, tempBelowLow,
            inputUnderVoltage} = v;
        repeat (10) @(negedge clk);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        host.wrReg(DEVICE_ADDR, {5'h0, a}, d);
    endtask
    task automatic rdCheck(input logic [2:0] a, input logic [7:0] exp);
        host.rdRegs(DEVICE_ADDR, {5'h0, a}, 1);
        check(host.rdBuf[0], exp);
    endtask
    task automatic stat(input logic [5:0] v, input logic [7:0] exp);
        sense(v);
        rdCheck(ADDR_STATUS_ONE, exp);
    endtask
    // The tests need about 42000 cycles; the margin covers slow bus phases
    initial begin
        repeat (60000) @(posedge clk);
        nErrors++;
        giveVerdict();
    end
    // ----
    // Tests
    // ----
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {overloadDetect, outputUnderVoltage, pulldownOvercurrent, tempAboveHigh, tempBelowLow,
            inputUnderVoltage} = 6'b000010;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (12) @(negedge clk);
        check(outs(), 8'h00);
        host.rdRegs(DEVICE_ADDR, {5'h0, ADDR_LEVEL_SELECT}, 4);
        for (int i = 0; i < 4; i++) begin
            check(host.rdBuf[i], 8'h00);
        end
        wr(ADDR_PROTECTION_CONTROL, 8'hff);
        check({7'h0, host.ackSeen}, 8'h01);
        rdCheck(ADDR_PROTECTION_CONTROL, 8'hc9);
        check(outs(), 8'h60);
        host.wrReg(DEVICE_ADDR ^ 7'h01, {5'h0, ADDR_PROTECTION_CONTROL}, 8'h00);
        check({7'h0, host.ackSeen}, 8'h00);
        check(outs(), 8'h60);
        wr(ADDR_PROTECTION_CONTROL, 8'h00);
        check(outs(), 8'h00);
        wr(ADDR_STATUS_ONE, 8'hff);
        rdCheck(ADDR_STATUS_ONE, 8'h00);
        stat(6'b100010, 8'h01);
        stat(6'b010010, 8'h04);
        stat(6'b000011, 8'h80);
        stat(6'b000100, 8'h40);
        stat(6'b000000, 8'h40);
        stat(6'b000010, 8'h00);
        stat(6'b110111, 8'hc5);
        sense(6'b001010);
        repeat (900) @(negedge clk);
        stat(6'b000010, 8'h00);
        sense(6'b001010);
        repeat (1100) @(negedge clk);
        stat(6'b001010, 8'h10);
        stat(6'b000010, 8'h00);
        // Bit 0 picks the thermal fault, bit 1 sets the matching level-clearing policy
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_LEVEL_SELECT, 8'h09);
            wr(ADDR_PROTECTION_CONTROL, k[1] ? (k[0] ? 8'h40 : 8'h08) : 8'h00);
            sense(k[0] ? 6'b000100 : 6'b100010);
            check(outs(), 8'h00);
            sense(6'b000010);
            check(outs(), k[1] ? 8'h00 : 8'h19);
            rdCheck(ADDR_LEVEL_SELECT, k[1] ? 8'h00 : 8'h09);
            wr(ADDR_LEVEL_SELECT, 8'h09);
            check(outs(), 8'h19);
        end
        wr(ADDR_PROTECTION_CONTROL, 8'h89);
        host.rdRegs(DEVICE_ADDR, {5'h0, ADDR_PROTECTION_CONTROL}, 4);
        for (int i = 0; i < 4; i++) begin
            check(host.rdBuf[i], i == 0 ? 8'h89 : 8'h00);
        end
        @(negedge clk);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        check(outs(), 8'h00);
        rst_n = 1'b1;
        repeat (12) @(negedge clk);
        rdCheck(ADDR_PROTECTION_CONTROL, 8'h00);
        giveVerdict();
    end
endmodule
`default_nettype wire
